// ### hw/mcu_pkg.sv
`default_nettype none
package mcu_pkg;
  localparam int unsigned MC_CLKS       = 3;
  localparam int unsigned TMR_PRESCALE  = 32;
  localparam int unsigned TMR_DIV       = MC_CLKS * TMR_PRESCALE;
  localparam int unsigned PC_W          = 12;
  localparam int unsigned ROM_DEPTH_DEF = 2048;
  localparam int unsigned RAM_DEPTH_DEF = 64;
  localparam int unsigned STK_DEPTH_DEF = 8;
  localparam int unsigned PSW_C_BIT     = 3;
  localparam int unsigned IND_SEL_BIT   = 0;
  localparam logic [11:0] PC_RST        = 12'h000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [3:0]  PSW_RST       = 4'h0;

  typedef enum logic [1:0] {
    ST_ADDR   = 2'h0,
    ST_STROBE = 2'h1,
    ST_EXEC   = 2'h3,
    ST_WAIT   = 2'h2
  } mcu_st_t;

  typedef enum logic [1:0] {
    TM_OFF  = 2'h0,
    TM_TIME = 2'h1,
    TM_CNT  = 2'h3
  } mcu_tmode_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_REG, SRC_IND, SRC_IMM} mcu_src_t;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_ANL, OP_ORL, OP_XRL, OP_INCA, OP_DECA,
    OP_CLRA, OP_CPLA, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_MOVA,
    OP_MOVR, OP_MOVI, OP_INCR, OP_DECR, OP_PANL, OP_PORL, OP_JMP, OP_PAGE_INDIRECT_JUMP,
    OP_DECREMENT_BRANCH_NONZERO, OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_JTF, OP_CALL, OP_RET,
    OP_RETURN_RESTORE_STATUS, OP_STRT, OP_STRC, OP_STOP, OP_ENTI, OP_DISTI, OP_SELMB0,
    OP_SELMB1, OP_CLRC, OP_CPLC
  } mcu_op_t;

  typedef struct packed {
    mcu_op_t  op;
    mcu_src_t src;
    logic     two_byte;
    logic     two_cyc;
  } mcu_dec_t;

  function automatic mcu_dec_t mcu_dec_fn(input logic [7:0] c);
    mcu_dec_t d;
    d = '{OP_NOP, SRC_NONE, 1'h0, 1'h0};
    casez (c)
      8'h03:        d = '{OP_ADD, SRC_IMM, 1'h1, 1'h1};
      8'h13:        d = '{OP_ADDC, SRC_IMM, 1'h1, 1'h1};
      8'h53:        d = '{OP_ANL, SRC_IMM, 1'h1, 1'h1};
      8'h43:        d = '{OP_ORL, SRC_IMM, 1'h1, 1'h1};
      8'hd3:        d = '{OP_XRL, SRC_IMM, 1'h1, 1'h1};
      8'h23:        d = '{OP_MOVA, SRC_IMM, 1'h1, 1'h1};
      8'h17:        d.op = OP_INCA;
      8'h07:        d.op = OP_DECA;
      8'h27:        d.op = OP_CLRA;
      8'h37:        d.op = OP_CPLA;
      8'h47:        d.op = OP_SWAP;
      8'he7:        d.op = OP_RL;
      8'hf7:        d.op = OP_RLC;
      8'h77:        d.op = OP_RR;
      8'h67:        d.op = OP_RRC;
      8'h97:        d.op = OP_CLRC;
      8'ha7:        d.op = OP_CPLC;
      8'h99, 8'h9a: d = '{OP_PANL, SRC_IMM, 1'h1, 1'h1};
      8'h89, 8'h8a: d = '{OP_PORL, SRC_IMM, 1'h1, 1'h1};
      8'hb3:        d = '{OP_PAGE_INDIRECT_JUMP, SRC_NONE, 1'h0, 1'h1};
      8'hf6:        d = '{OP_JC, SRC_NONE, 1'h1, 1'h1};
      8'he6:        d = '{OP_JNC, SRC_NONE, 1'h1, 1'h1};
      8'hc6:        d = '{OP_JZ, SRC_NONE, 1'h1, 1'h1};
      8'h96:        d = '{OP_JNZ, SRC_NONE, 1'h1, 1'h1};
      8'h16:        d = '{OP_JTF, SRC_NONE, 1'h1, 1'h1};
      8'h83:        d = '{OP_RET, SRC_NONE, 1'h0, 1'h1};
      8'h93:        d = '{OP_RETURN_RESTORE_STATUS, SRC_NONE, 1'h0, 1'h1};
      8'h55:        d.op = OP_STRT;
      8'h45:        d.op = OP_STRC;
      8'h65:        d.op = OP_STOP;
      8'h25:        d.op = OP_ENTI;
      8'h35:        d.op = OP_DISTI;
      8'he5:        d.op = OP_SELMB0;
      8'hf5:        d.op = OP_SELMB1;
      8'b0110_1???: d = '{OP_ADD, SRC_REG, 1'h0, 1'h0};
      8'b0110_000?: d = '{OP_ADD, SRC_IND, 1'h0, 1'h0};
      8'b0111_1???: d = '{OP_ADDC, SRC_REG, 1'h0, 1'h0};
      8'b0111_000?: d = '{OP_ADDC, SRC_IND, 1'h0, 1'h0};
      8'b0101_1???: d = '{OP_ANL, SRC_REG, 1'h0, 1'h0};
      8'b0101_000?: d = '{OP_ANL, SRC_IND, 1'h0, 1'h0};
      8'b0100_1???: d = '{OP_ORL, SRC_REG, 1'h0, 1'h0};
      8'b0100_000?: d = '{OP_ORL, SRC_IND, 1'h0, 1'h0};
      8'b1101_1???: d = '{OP_XRL, SRC_REG, 1'h0, 1'h0};
      8'b1101_000?: d = '{OP_XRL, SRC_IND, 1'h0, 1'h0};
      8'b1111_1???: d = '{OP_MOVA, SRC_REG, 1'h0, 1'h0};
      8'b1111_000?: d = '{OP_MOVA, SRC_IND, 1'h0, 1'h0};
      8'b1010_1???, 8'b1010_000?: d.op = OP_MOVR;
      8'b1011_1???, 8'b1011_000?: d = '{OP_MOVI, SRC_IMM, 1'h1, 1'h1};
      8'b0001_1???: d = '{OP_INCR, SRC_REG, 1'h0, 1'h0};
      8'b0001_000?: d = '{OP_INCR, SRC_IND, 1'h0, 1'h0};
      8'b1100_1???: d = '{OP_DECR, SRC_REG, 1'h0, 1'h0};
      8'b1110_1???: d = '{OP_DECREMENT_BRANCH_NONZERO, SRC_REG, 1'h1, 1'h1};
      8'b???0_0100: d = '{OP_JMP, SRC_NONE, 1'h1, 1'h1};
      8'b???1_0100: d = '{OP_CALL, SRC_NONE, 1'h1, 1'h1};
      default:      d = '{OP_NOP, SRC_NONE, 1'h0, 1'h0};
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// ### hw/mcu_sub_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcu_sub_if;
  import mcu_pkg::*;
  mcu_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] res;
  logic       cout;
  logic       start_tmr;
  logic       start_cnt;
  logic       stop_cnt;
  logic       ev_in;
  logic       ovf;
  logic [7:0] cnt;
  modport core (output op, a, b, cin, start_tmr, start_cnt, stop_cnt, ev_in,
                input res, cout, ovf, cnt);
  modport alu (input op, a, b, cin, output res, cout);
  modport tmr (input start_tmr, start_cnt, stop_cnt, ev_in,
               output ovf, cnt);
endinterface
`default_nettype wire

// ### hw/mcu_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_alu (
  mcu_sub_if.alu io  // Operands and result
);
  import mcu_pkg::*;

  always_comb
  begin
    io.res  = io.a;
    io.cout = io.cin;
    case (io.op)
      OP_ADD:           {io.cout, io.res} = {1'h0, io.a} + {1'h0, io.b};
      OP_ADDC:          {io.cout, io.res} = {1'h0, io.a} + {1'h0, io.b}
                                            + {8'h00, io.cin};
      OP_ANL, OP_PANL:  io.res = io.a & io.b;
      OP_ORL, OP_PORL:  io.res = io.a | io.b;
      OP_XRL:           io.res = io.a ^ io.b;
      OP_INCA:          io.res = io.a + 8'h01;
      OP_DECA:          io.res = io.a - 8'h01;
      OP_CLRA:          io.res = 8'h00;
      OP_CPLA:          io.res = ~io.a;
      OP_SWAP:          io.res = {io.a[3:0], io.a[7:4]};
      OP_RL:            io.res = {io.a[6:0], io.a[7]};
      OP_RLC:           {io.cout, io.res} = {io.a, io.cin};
      OP_RR:            io.res = {io.a[0], io.a[7:1]};
      OP_RRC:           {io.res, io.cout} = {io.cin, io.a};
      OP_MOVA:          io.res = io.b;
      default:          io.res = io.a;
    endcase
  end
endmodule  // mcu_alu
`default_nettype wire

// ### hw/mcu_tmr.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_tmr #(
  parameter int unsigned DIV = mcu_pkg::TMR_DIV  // Clocks per timer tick
) (
  input  wire logic  clk,    // Core clock
  input  wire logic  rst_n,  // Synchronous reset, active low
  mcu_sub_if.tmr     io      // Commands, count and overflow
);
  import mcu_pkg::*;

  localparam int unsigned PW = $clog2(DIV);

  mcu_tmode_t    mode_r, mode_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic [7:0]    cnt_r, cnt_nxt;
  logic          ev_r;
  logic          tick;

  always_comb
  begin
    mode_nxt = mode_r;
    pre_nxt  = pre_r;
    tick     = 1'h0;
    unique case (mode_r)
      TM_OFF:  tick = 1'h0;
      TM_TIME:
        if (pre_r == PW'(DIV - 1))
        begin
          pre_nxt = '0;
          tick    = 1'h1;
        end
        else
          pre_nxt = pre_r + PW'(1);
      TM_CNT:  tick = ev_r & ~io.ev_in;
      default: mode_nxt = TM_OFF;
    endcase
    // Start and stop keep the count value
    if (io.start_tmr)
    begin
      mode_nxt = TM_TIME;
      pre_nxt  = '0;
    end
    else if (io.start_cnt)
      mode_nxt = TM_CNT;
    else if (io.stop_cnt)
      mode_nxt = TM_OFF;
    cnt_nxt = tick ? cnt_r + 8'h01 : cnt_r;
    io.ovf  = tick && (cnt_r == 8'hff);
    io.cnt  = cnt_r;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_r <= TM_OFF;
      pre_r  <= '0;
      cnt_r  <= BYTE_RST;
      ev_r   <= 1'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      ev_r   <= io.ev_in;
    end
  end
endmodule  // mcu_tmr
`default_nettype wire

// ### hw/mcu_core.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_core #(
  parameter int unsigned ROM_DEPTH = mcu_pkg::ROM_DEPTH_DEF,  // Internal ROM
  parameter int unsigned RAM_DEPTH = mcu_pkg::RAM_DEPTH_DEF,  // Data RAM
  parameter int unsigned STK_DEPTH = mcu_pkg::STK_DEPTH_DEF,  // Stack levels
  parameter int unsigned TMR_DIV   = mcu_pkg::TMR_DIV         // Timer tick
) (
  input  wire logic                         core_clk,  // Core clock
  input  wire logic                         rst_n,     // Sync reset
  input  wire logic                         ss_n,      // Single step
  input  wire logic                         external_access_input,  // Ext
  output logic [$clog2(ROM_DEPTH)-1:0]      int_rom_addr,  // ROM address
  input  wire logic [7:0]                   int_rom_data,  // ROM byte
  output logic [mcu_pkg::PC_W-1:0]          ext_addr,      // Program addr
  input  wire logic [7:0]                   ext_bus_in,    // External byte
  output logic                              ale,           // Latch strobe
  output logic                              program_fetch_strobe_n,  // Fetch
  input  wire logic                         t1_in,         // Event input
  output logic [7:0]                        port1_out,     // Port 1 latch
  output logic [7:0]                        port2_out,     // Port 2 latch
  output logic [7:0]                        acc_out,       // Accumulator
  output logic                              carry_out,     // Carry flag
  output logic                              timer_overflow_flag,  // Flag
  output logic                              timer_irq_req, // Timer request
  output logic                              memory_bank_select,  // PC bit 11 on jumps
  output logic                              step_wait      // Stepping halt
);
  import mcu_pkg::*;

  localparam int unsigned AW  = $clog2(RAM_DEPTH);
  localparam int unsigned SPW = $clog2(STK_DEPTH);

  mcu_sub_if sub ();

  mcu_alu u_alu (
    .io (sub.alu)
  );

  mcu_tmr #(
    .DIV (TMR_DIV)
  ) u_tmr (
    .clk   (core_clk),
    .rst_n (rst_n),
    .io    (sub.tmr)
  );

  mcu_st_t         st_r, st_nxt;
  logic            cyc_r, cyc_nxt;
  logic [7:0]      opc_r, opc_nxt;
  logic [7:0]      byte_r, byte_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0]      acc_r, acc_nxt;
  logic [3:0]      psw_r, psw_nxt;
  logic [SPW-1:0]  sp_r, sp_nxt;
  logic [15:0]     stk_r [STK_DEPTH];
  logic [15:0]     stk_nxt [STK_DEPTH];
  logic [7:0]      ram_r [RAM_DEPTH];
  logic [7:0]      ram_nxt [RAM_DEPTH];
  logic [7:0]      p1_r, p1_nxt;
  logic [7:0]      p2_r, p2_nxt;
  logic            mb_r, mb_nxt;
  logic            tien_r, tien_nxt;
  logic            tf_r, tf_nxt;
  logic            tirq_r, tirq_nxt;

  logic [7:0]      cur;
  mcu_dec_t        dec;
  logic            last;
  logic            exec;
  logic            fetch;
  logic            ext_fetch;
  logic [AW-1:0]   rsel;
  logic [AW-1:0]   indaddr;
  logic [AW-1:0]   waddr;
  logic [7:0]      regv;
  logic [7:0]      opnd;
  logic [7:0]      dj;
  logic [SPW-1:0]  sp_dec;
  logic            is_port;

  // Decode the fetched opcode in cycle 1, the held one in cycle 2
  assign cur       = cyc_r ? opc_r : byte_r;
  assign dec       = mcu_dec_fn(cur);
  assign last      = cyc_r | ~dec.two_cyc;
  assign exec      = (st_r == ST_EXEC) && last;
  assign fetch     = (st_r == ST_STROBE) && (!cyc_r || dec.two_byte);
  assign ext_fetch = external_access_input ||
                     (pc_r >= PC_W'(ROM_DEPTH));
  assign rsel      = AW'(cur[2:0]);
  assign indaddr   = ram_r[AW'(cur[IND_SEL_BIT])][AW-1:0];
  assign waddr     = cur[3] ? rsel : indaddr;
  assign regv      = ram_r[rsel];
  assign dj        = regv - 8'h01;
  assign sp_dec    = sp_r - SPW'(1);
  assign is_port   = (dec.op == OP_PANL) || (dec.op == OP_PORL);

  always_comb
  begin
    unique case (dec.src)
      SRC_REG: opnd = regv;
      SRC_IND: opnd = ram_r[indaddr];
      SRC_IMM: opnd = byte_r;
      SRC_NONE: opnd = 8'h00;
    endcase
  end

  // Port 1 is code 01, port 2 is code 10
  assign sub.op        = dec.op;
  assign sub.a         = is_port ? (cur[0] ? p1_r : p2_r) : acc_r;
  assign sub.b         = opnd;
  assign sub.cin       = psw_r[PSW_C_BIT];
  assign sub.start_tmr = exec && (dec.op == OP_STRT);
  assign sub.start_cnt = exec && (dec.op == OP_STRC);
  assign sub.stop_cnt  = exec && (dec.op == OP_STOP);
  assign sub.ev_in     = t1_in;

  always_comb
  begin
    st_nxt  = st_r;
    cyc_nxt = cyc_r;
    opc_nxt = opc_r;
    unique case (st_r)
      ST_ADDR:   st_nxt = ST_STROBE;
      ST_STROBE: st_nxt = ST_EXEC;
      ST_EXEC:
        if (last)
        begin
          cyc_nxt = 1'h0;
          st_nxt  = ss_n ? ST_ADDR : ST_WAIT;
        end
        else
        begin
          cyc_nxt = 1'h1;
          opc_nxt = byte_r;
          st_nxt  = ST_ADDR;
        end
      ST_WAIT:   st_nxt = ss_n ? ST_ADDR : ST_WAIT;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r  <= ST_ADDR;
      cyc_r <= 1'h0;
      opc_r <= BYTE_RST;
    end
    else
    begin
      st_r  <= st_nxt;
      cyc_r <= cyc_nxt;
      opc_r <= opc_nxt;
    end
  end

  always_comb
  begin
    byte_nxt = byte_r;
    pc_nxt   = pc_r;
    acc_nxt  = acc_r;
    psw_nxt  = psw_r;
    sp_nxt   = sp_r;
    stk_nxt  = stk_r;
    ram_nxt  = ram_r;
    p1_nxt   = p1_r;
    p2_nxt   = p2_r;
    mb_nxt   = mb_r;
    tien_nxt = tien_r;
    tf_nxt   = tf_r;
    // Increment stays inside the current 2K bank
    if (fetch)
    begin
      byte_nxt = ext_fetch ? ext_bus_in : int_rom_data;
      pc_nxt   = {pc_r[PC_W-1], pc_r[PC_W-2:0] + 11'h001};
    end
    if (exec)
    begin
      case (dec.op)
        OP_ADD, OP_ADDC, OP_RLC, OP_RRC:
        begin
          acc_nxt            = sub.res;
          psw_nxt[PSW_C_BIT] = sub.cout;
        end
        OP_ANL, OP_ORL, OP_XRL, OP_INCA, OP_DECA, OP_CLRA, OP_CPLA,
        OP_SWAP, OP_RL, OP_RR, OP_MOVA:
          acc_nxt = sub.res;
        OP_CLRC:   psw_nxt[PSW_C_BIT] = 1'h0;
        OP_CPLC:   psw_nxt[PSW_C_BIT] = ~psw_r[PSW_C_BIT];
        OP_MOVR:   ram_nxt[waddr] = acc_r;
        OP_MOVI:   ram_nxt[waddr] = byte_r;
        OP_INCR:   ram_nxt[waddr] = opnd + 8'h01;
        OP_DECR:   ram_nxt[waddr] = dj;
        OP_PANL, OP_PORL:
          if (cur[0])
            p1_nxt = sub.res;
          else
            p2_nxt = sub.res;
        OP_JMP:    pc_nxt = {mb_r, cur[7:5], byte_r};
        OP_PAGE_INDIRECT_JUMP:   pc_nxt[7:0] = acc_r;
        OP_DECREMENT_BRANCH_NONZERO:
        begin
          ram_nxt[rsel] = dj;
          if (dj != 8'h00)
            pc_nxt[7:0] = byte_r;
        end
        OP_JC:
          if (psw_r[PSW_C_BIT])
            pc_nxt[7:0] = byte_r;
        OP_JNC:
          if (!psw_r[PSW_C_BIT])
            pc_nxt[7:0] = byte_r;
        OP_JZ:
          if (acc_r == 8'h00)
            pc_nxt[7:0] = byte_r;
        OP_JNZ:
          if (acc_r != 8'h00)
            pc_nxt[7:0] = byte_r;
        OP_JTF:
        begin
          if (tf_r)
            pc_nxt[7:0] = byte_r;
          tf_nxt = 1'h0;
        end
        OP_CALL:
        begin
          stk_nxt[sp_r] = {psw_r, pc_r};
          sp_nxt        = sp_r + SPW'(1);
          pc_nxt        = {mb_r, cur[7:5], byte_r};
        end
        OP_RET, OP_RETURN_RESTORE_STATUS:
        begin
          sp_nxt = sp_dec;
          pc_nxt = stk_r[sp_dec][PC_W-1:0];
          if (dec.op == OP_RETURN_RESTORE_STATUS)
            psw_nxt = stk_r[sp_dec][15:12];
        end
        OP_ENTI:   tien_nxt = 1'h1;
        OP_DISTI:  tien_nxt = 1'h0;
        OP_SELMB0: mb_nxt = 1'h0;
        OP_SELMB1: mb_nxt = 1'h1;
        default:   acc_nxt = acc_r;
      endcase
    end
    // An overflow in the testing cycle is not lost
    if (sub.ovf)
      tf_nxt = 1'h1;
    tirq_nxt = tien_nxt & tf_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      byte_r <= BYTE_RST;
      pc_r   <= PC_RST;
      acc_r  <= BYTE_RST;
      psw_r  <= PSW_RST;
      sp_r   <= '0;
      stk_r  <= '{default: 16'h0000};
      ram_r  <= '{default: BYTE_RST};
      p1_r   <= BYTE_RST;
      p2_r   <= BYTE_RST;
      mb_r   <= 1'h0;
      tien_r <= 1'h0;
      tf_r   <= 1'h0;
      tirq_r <= 1'h0;
    end
    else
    begin
      byte_r <= byte_nxt;
      pc_r   <= pc_nxt;
      acc_r  <= acc_nxt;
      psw_r  <= psw_nxt;
      sp_r   <= sp_nxt;
      stk_r  <= stk_nxt;
      ram_r  <= ram_nxt;
      p1_r   <= p1_nxt;
      p2_r   <= p2_nxt;
      mb_r   <= mb_nxt;
      tien_r <= tien_nxt;
      tf_r   <= tf_nxt;
      tirq_r <= tirq_nxt;
    end
  end

  assign ale                    = (st_r == ST_ADDR);
  assign program_fetch_strobe_n = !(fetch && ext_fetch);
  assign int_rom_addr           = pc_r[$clog2(ROM_DEPTH)-1:0];
  assign ext_addr               = pc_r;
  assign port1_out              = p1_r;
  assign port2_out              = p2_r;
  assign acc_out                = acc_r;
  assign carry_out              = psw_r[PSW_C_BIT];
  assign timer_overflow_flag    = tf_r;
  assign timer_irq_req          = tirq_r;
  assign memory_bank_select     = mb_r;
  assign step_wait              = (st_r == ST_WAIT);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic [7:0] acc_rl;
  logic [8:0] acc_rlc;
  assign acc_rl  = {acc_r[6:0], acc_r[7]};
  assign acc_rlc = {acc_r, psw_r[PSW_C_BIT]};

  chk_ale_single: assert property (ale |=> !ale [*2])
    else $error("latch strobe high twice in a machine cycle");
  chk_fetch_strobe: assert property (
    !program_fetch_strobe_n |-> $past(ale) ##1 (st_r == ST_EXEC))
    else $error("fetch strobe outside a fetch slot");
  chk_ext_fetch: assert property (
    external_access_input && (st_r == ST_STROBE) && !cyc_r
    |-> !program_fetch_strobe_n)
    else $error("opcode fetch not external with access input high");
  chk_step_hold: assert property (
    exec && !ss_n |=> step_wait && !ale)
    else $error("no wait after instruction with step low");
  chk_rl_carry: assert property (
    exec && (dec.op == OP_RL)
    |=> (acc_r == $past(acc_rl)) && $stable(psw_r))
    else $error("rotate left wrong or carry touched");
  chk_rlc_carry: assert property (
    exec && (dec.op == OP_RLC) |=> {psw_r[PSW_C_BIT], acc_r} == $past(acc_rlc))
    else $error("rotate through carry wrong");
  chk_jc_taken: assert property (
    exec && (dec.op == OP_JC) && psw_r[PSW_C_BIT]
    |=> pc_r[7:0] == $past(byte_r))
    else $error("jump on carry not taken");
  chk_jz_fall: assert property (
    exec && (dec.op == OP_JZ) && (acc_r != 8'h00) |=> $stable(pc_r))
    else $error("jump on zero taken with nonzero accumulator");
  chk_jtf_clear: assert property (
    exec && (dec.op == OP_JTF) && !sub.ovf |=> !tf_r)
    else $error("timer flag not cleared by its jump");
  chk_decrement_branch_nonzero_zero: assert property (
    exec && (dec.op == OP_DECREMENT_BRANCH_NONZERO) && (regv == 8'h01) |=> $stable(pc_r))
    else $error("loop branch taken at zero");
  chk_call_push: assert property (
    exec && (dec.op == OP_CALL)
    |=> (sp_r == $past(sp_r) + SPW'(1)) && (pc_r[PC_W-1] == $past(mb_r)))
    else $error("call did not push or bank bit wrong");
  chk_stop_hold: assert property (
    exec && (dec.op == OP_STOP) |=> ##1 $stable(sub.cnt) [*3])
    else $error("count moved after stop");
  chk_tirq_en: assert property (
    exec && (dec.op == OP_DISTI) |=> !timer_irq_req)
    else $error("timer request with request disabled");

  cov_call: cover property (exec && (dec.op == OP_CALL));
  cov_step: cover property (step_wait ##1 !step_wait);
  cov_ovf:  cover property (sub.ovf);
  cov_loop: cover property (exec && (dec.op == OP_DECREMENT_BRANCH_NONZERO) && (dj != 8'h00));
endmodule  // mcu_core
`default_nettype wire

// ### test/mcu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_mem_model (
  input  wire logic [10:0] int_rom_addr,            // Internal address
  output logic      [7:0]  int_rom_data,            // Internal byte
  input  wire logic [11:0] ext_addr,                // External address
  input  wire logic        program_fetch_strobe_n,  // Fetch strobe
  output logic      [7:0]  ext_bus_in               // External bus
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_r = 8'h00;
  assign int_rom_data = mem[{1'b0, int_rom_addr}];
  // Released bus shows the inverse of the last byte, not a stale copy
  always @(program_fetch_strobe_n or ext_addr)
    if (!program_fetch_strobe_n)
      last_r = mem[ext_addr];
  assign ext_bus_in = program_fetch_strobe_n ? ~last_r : mem[ext_addr];
endmodule  // mcu_mem_model
`default_nettype wire

// ### test/mcu8_instruction_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mcu8_instruction_decoder_bench;
  localparam logic [7:0] PROG [0:37] = '{8'h23, 8'h80, 8'hf7, 8'hf6, 8'h07,
    8'h23, 8'h55, 8'h89, 8'hf0, 8'h99, 8'h3c, 8'h8a, 8'h0a, 8'hc6, 8'h11,
    8'h23, 8'h66, 8'h23, 8'h0c, 8'he7, 8'hb3, 8'h00, 8'h00, 8'h00, 8'h14,
    8'h20, 8'h23, 8'h77, 8'h25, 8'h55, 8'h04, 8'h1e, 8'hb8, 8'h02, 8'he8,
    8'h22, 8'h83, 8'h00};
  // Indirect store, event count, flag jump, stop, status return, bank jump
  localparam logic [7:0] PROG2 [0:26] = '{8'h23, 8'h05, 8'hb9, 8'h07,
    8'ha1, 8'h27, 8'hff, 8'hc6, 8'h00, 8'h25, 8'h45, 8'h16, 8'h0f, 8'h04,
    8'h0b, 8'h65, 8'h35, 8'h14, 8'h18, 8'h04, 8'h13, 8'h00, 8'h00, 8'h00,
    8'ha7, 8'hf5, 8'h93};
  logic core_clk = 1'b0, rst_n = 1'b0, ss_n = 1'b1, ea = 1'b0, t1 = 1'b0;
  logic [10:0] rom_a;
  logic [7:0]  rom_d, bus_d, p1, p2, acc;
  logic [11:0] addr;
  logic ale, fs_n, cy, tf, irq, mb, sw;
  int err_count = 0;
  int checks = 0;
  mcu_core #(.TMR_DIV(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .ss_n(ss_n), .external_access_input(ea), .int_rom_addr(rom_a),
    .int_rom_data(rom_d), .ext_addr(addr), .ext_bus_in(bus_d), .ale(ale),
    .program_fetch_strobe_n(fs_n), .t1_in(t1), .port1_out(p1),
    .port2_out(p2), .acc_out(acc), .carry_out(cy), .timer_overflow_flag(tf),
    .timer_irq_req(irq), .memory_bank_select(mb), .step_wait(sw));
  mcu_mem_model mem_u (.int_rom_addr(rom_a), .int_rom_data(rom_d),
    .ext_addr(addr), .program_fetch_strobe_n(fs_n), .ext_bus_in(bus_d));
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [11:0] seen,
                     input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic ext);
    rst_n = 1'b0;
    ea = ext;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk("ale_first", ale, 1);
    chk("acc_rst", acc, 0);
    chk("port1_rst", p1, 0);
    @(negedge core_clk);
    chk("ale_second", ale, 0);
    $display("test reset done");
  endtask
  task automatic t_run(input logic ext);
    int n = 0;
    int i;
    for (i = 0; i < 3000 && irq !== 1'b1; i++)
    begin
      @(negedge core_clk);
      if (fs_n === 1'b0)
        n++;
    end
    if (i == 3000)
    begin
      err_count++;
      final_report();
    end
    chk("ext_fetch", n != 0, ext);
    chk("flag", tf, 1);
    chk("irq", irq, 1);
    chk("acc", acc, 12'h77);
    chk("carry", cy, 1);
    chk("port1", p1, 12'h30);
    chk("port2", p2, 12'h0a);
    $display("test run ext=%0d done", ext);
  endtask
  task automatic t_bus();
    int na = 0;
    int nf = 0;
    repeat (300)
    begin
      @(negedge core_clk);
      na += (ale === 1'b1);
      nf += (fs_n === 1'b0);
    end
    chk("ale_count", na, 100);
    chk("fetch_count", nf, 100);
    $display("test bus done");
  endtask
  task automatic t_step();
    int i;
    int na = 0;
    ss_n = 1'b0;
    for (i = 0; i < 12 && sw !== 1'b1; i++)
      @(negedge core_clk);
    chk("step_wait", sw, 1);
    repeat (9)
    begin
      @(negedge core_clk);
      na += (ale === 1'b1);
    end
    chk("ale_in_wait", na, 0);
    ss_n = 1'b1;
    for (i = 0; i < 3 && ale !== 1'b1; i++)
      @(negedge core_clk);
    chk("ale_resume", ale, 1);
    $display("test step done");
  endtask
  task automatic t_flags();
    int i;
    int seen = 0;
    for (i = 0; i < 27; i++)
      mem_u.mem[i] = PROG2[i];
    mem_u.mem[12'h813] = 8'h04;
    mem_u.mem[12'h814] = 8'h13;
    do_reset(1'b0);
    for (i = 0; i < 1500 && addr[11] !== 1'b1; i++)
    begin
      @(negedge core_clk);
      t1 = ~t1;
      seen |= (irq === 1'b1);
    end
    if (i == 1500)
    begin
      err_count++;
      final_report();
    end
    chk("irq_seen", seen, 1);
    chk("acc_ind", acc, 12'h05);
    chk("flag_clr", tf, 0);
    chk("irq_off", irq, 0);
    chk("carry_rst", cy, 0);
    chk("bank", mb, 1);
    chk("bank_jump", addr[11], 1);
    $display("test flags done");
  endtask
  initial
  begin
    for (int a = 0; a < 4096; a++)
      mem_u.mem[a] = (a < 38) ? PROG[a] : 8'h00;
    do_reset(1'b0);
    t_run(1'b0);
    do_reset(1'b1);
    t_run(1'b1);
    t_bus();
    t_step();
    t_flags();
    final_report();
  end
endmodule  // mcu8_instruction_decoder_bench
`default_nettype wire
